// >>> acc_conversion_control.sv
// Conversion control: start, busy, done, abort and channel selection for the converter core.
//
// Notes on behaviour
// - Control register bits 7 and 6 read the two least significant bits of the 10-bit result.
// - With external trigger enable set, software, a rising start pin edge or a PWM edge may start.
// - PWM starts act only when second control bit 1 and the external trigger enable are both one.
// - One of four PWM channels is selectable, with programmable edge and start delay.
// - The done flag sets when a result is ready and raises the interrupt when enabled.
// - Hardware never clears the done flag; only a software write of zero does.
// - Writing one to the busy bit starts a conversion; the start pin also sets it when enabled.
// - The busy bit stays high during conversion and clears right after the done flag sets.
// - Writing zero to the busy bit during a conversion aborts it.
// - Pin and PWM starts are ignored while busy or done is high; software starts while busy or when the write keeps done at one.
// - Done and busy decode to idle, running, complete or a transient state.
// - The three-bit channel field selects the input, codes 000, 001, 010 inputs 0, 1, 2.
`timescale 1ns/1ps
`include "acc_defines.svh"

module acc_conversion_control #(
	parameter int PWM_CHANNELS = 4,
	parameter int RESULT_W     = 10,
	parameter int CH_W         = 3
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic [`ACC_ADDR_W-1:0]   addr_i,
	input  wire logic [7:0]               wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic      [7:0]               rdata_o,
	input  wire logic                     ext_start_i,
	input  wire logic [PWM_CHANNELS-1:0]  pwm_i,
	input  wire logic                     core_ready_i,
	input  wire logic [RESULT_W-1:0]      core_result_i,
	output acc_pkg::acc_core_req_t        core_req_o,
	output logic                          irq_o
);

	if (PWM_CHANNELS != 4 || RESULT_W != 10 || CH_W != 3) begin : g_bad_params
		$error("Unsupported parameter values.");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, change counted when stages two and three agree.

	logic [2:0]              ext_sync_reg;
	logic [2:0]              ext_sync_next;
	logic                    ext_level_reg;
	logic                    ext_level_next;
	logic [PWM_CHANNELS-1:0] pwm_s1_reg, pwm_s2_reg, pwm_s3_reg;
	logic [PWM_CHANNELS-1:0] pwm_level_reg;
	logic [PWM_CHANNELS-1:0] pwm_level_next;

	always_comb begin
		ext_sync_next  = {ext_sync_reg[1:0], ext_start_i};
		ext_level_next = ext_level_reg;
		if (ext_sync_reg[1] == ext_sync_reg[2])
			ext_level_next = ext_sync_reg[2];
		for (int i = 0; i < PWM_CHANNELS; i++) begin
			pwm_level_next[i] = pwm_level_reg[i];
			if (pwm_s2_reg[i] == pwm_s3_reg[i])
				pwm_level_next[i] = pwm_s3_reg[i];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_sync_reg  <= 3'h0;
			ext_level_reg <= 1'b0;
			pwm_s1_reg    <= '0;
			pwm_s2_reg    <= '0;
			pwm_s3_reg    <= '0;
			pwm_level_reg <= '0;
		end else begin
			ext_sync_reg  <= ext_sync_next;
			ext_level_reg <= ext_level_next;
			pwm_s1_reg    <= pwm_i;
			pwm_s2_reg    <= pwm_s1_reg;
			pwm_s3_reg    <= pwm_s2_reg;
			pwm_level_reg <= pwm_level_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers and conversion sequencing.

	logic [7:0]            ctrl_reg, ctrl_next;
	logic [7:0]            ctrl2_reg, ctrl2_next;
	logic [7:0]            delay_reg, delay_next;
	logic [7:0]            dcount_reg, dcount_next;
	logic [1:0]            stat_reg, stat_next;
	logic [1:0]            mask_reg, mask_next;
	logic [RESULT_W-1:0]   result_reg, result_next;
	logic [7:0]            rdata_reg, rdata_next;
	logic                  start_reg, start_next;
	logic                  abort_reg, abort_next;
	acc_pkg::acc_state_t   state_reg, state_next;

	logic       ext_rise;
	logic       pwm_edge;
	logic [1:0] pwm_sel;
	logic       pwm_cur, pwm_prev;
	logic       wr_ctrl;
	logic       sw_start;
	logic       sw_abort;
	logic       hw_start;
	logic       blocked;
	logic       done_evt;

	function automatic logic hit(input logic [`ACC_ADDR_W-1:0] a, input logic [`ACC_ADDR_W-1:0] o);
		hit = (a == o);
	endfunction : hit

	function automatic logic edge_seen(input logic prev, input logic cur, input logic falling);
		edge_seen = falling ? (prev & ~cur) : (~prev & cur);
	endfunction : edge_seen

	always_comb begin
		pwm_sel  = ctrl2_reg[`ACC_BIT_PWM_SEL_HI:`ACC_BIT_PWM_SEL_LO];
		pwm_cur  = pwm_level_next[pwm_sel];
		pwm_prev = pwm_level_reg[pwm_sel];
		pwm_edge = edge_seen(pwm_prev, pwm_cur, ctrl2_reg[`ACC_BIT_EDGE_FALL]);
		ext_rise = edge_seen(ext_level_reg, ext_level_next, 1'b0);
		wr_ctrl  = wr_i && hit(addr_i, `ACC_OFF_CTRL);
		blocked  = ctrl_reg[`ACC_BIT_BUSY] | ctrl_reg[`ACC_BIT_DONE];
		// Clearing done and setting busy in one write may start a new conversion.
		sw_start = wr_ctrl && wdata_i[`ACC_BIT_BUSY] && !ctrl_reg[`ACC_BIT_BUSY]
		           && !wdata_i[`ACC_BIT_DONE];
		sw_abort = wr_ctrl && !wdata_i[`ACC_BIT_BUSY] && ctrl_reg[`ACC_BIT_BUSY];
		hw_start = ctrl_reg[`ACC_BIT_EXT_EN] && !blocked && (ext_rise
		           || (ctrl2_reg[`ACC_BIT_TRIG_PWM] && pwm_edge));

		ctrl_next   = ctrl_reg;
		dcount_next = dcount_reg;
		result_next = result_reg;
		state_next  = state_reg;
		start_next  = 1'b0;
		abort_next  = 1'b0;
		done_evt    = 1'b0;

		if (wr_ctrl) begin
			ctrl_next[`ACC_BIT_EXT_EN] = wdata_i[`ACC_BIT_EXT_EN];
			// Channel field changes are trusted to come only while idle.
			ctrl_next[`ACC_BIT_CH_HI:`ACC_BIT_CH_LO] = wdata_i[`ACC_BIT_CH_HI:`ACC_BIT_CH_LO];
			if (!wdata_i[`ACC_BIT_DONE])
				ctrl_next[`ACC_BIT_DONE] = 1'b0;
			if (sw_abort) begin
				ctrl_next[`ACC_BIT_BUSY] = 1'b0;
				abort_next = 1'b1;
				state_next = acc_pkg::ACC_IDLE;
			end
		end

		case (state_reg)
			acc_pkg::ACC_IDLE: begin
				if (sw_start) begin
					ctrl_next[`ACC_BIT_BUSY] = 1'b1;
					start_next = 1'b1;
					state_next = acc_pkg::ACC_CONVERT;
				end else if (hw_start) begin
					ctrl_next[`ACC_BIT_BUSY] = 1'b1;
					dcount_next = delay_reg;
					state_next  = acc_pkg::ACC_DELAY;
				end
			end
			acc_pkg::ACC_DELAY: begin
				if (!sw_abort) begin
					if (dcount_reg == 8'h00) begin
						start_next = 1'b1;
						state_next = acc_pkg::ACC_CONVERT;
					end else begin
						dcount_next = dcount_reg - 8'h01;
					end
				end
			end
			acc_pkg::ACC_CONVERT: begin
				if (!sw_abort && core_ready_i) begin
					result_next = core_result_i;
					ctrl_next[`ACC_BIT_DONE] = 1'b1;
					done_evt = 1'b1;
					state_next = acc_pkg::ACC_DONE;
				end
			end
			acc_pkg::ACC_DONE: begin
				ctrl_next[`ACC_BIT_BUSY] = 1'b0;
				state_next = acc_pkg::ACC_IDLE;
			end
			default: state_next = acc_pkg::ACC_IDLE;
		endcase

	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_reg   <= `ACC_CTRL_RESET;
			dcount_reg <= 8'h00;
			result_reg <= '0;
			start_reg  <= 1'b0;
			abort_reg  <= 1'b0;
			state_reg  <= acc_pkg::ACC_IDLE;
		end else begin
			ctrl_reg   <= ctrl_next;
			dcount_reg <= dcount_next;
			result_reg <= result_next;
			start_reg  <= start_next;
			abort_reg  <= abort_next;
			state_reg  <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trigger configuration: second control register and start delay.

	always_comb begin
		ctrl2_next = ctrl2_reg;
		delay_next = delay_reg;
		if (wr_i && hit(addr_i, `ACC_OFF_CTRL2))
			ctrl2_next = wdata_i;
		if (wr_i && hit(addr_i, `ACC_OFF_DELAY))
			delay_next = wdata_i;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl2_reg <= `ACC_CTRL2_RESET;
			delay_reg <= `ACC_DELAY_RESET;
		end else begin
			ctrl2_reg <= ctrl2_next;
			delay_reg <= delay_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask; an event in the cycle of its clear keeps the bit set.

	always_comb begin
		mask_next = mask_reg;
		stat_next = stat_reg;
		if (wr_i && hit(addr_i, `ACC_OFF_IRQ_MASK))
			mask_next = wdata_i[`ACC_IRQ_W-1:0];
		if (wr_i && hit(addr_i, `ACC_OFF_IRQ_STAT))
			stat_next = stat_reg & ~wdata_i[`ACC_IRQ_W-1:0];
		if (done_evt)
			stat_next[`ACC_IRQ_DONE] = 1'b1;
		if (sw_abort)
			stat_next[`ACC_IRQ_ABORT] = 1'b1;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stat_reg <= '0;
			mask_reg <= '0;
		end else begin
			stat_reg <= stat_next;
			mask_reg <= mask_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, registered and zero outside the cycle after a read.

	always_comb begin
		rdata_next = 8'h00;
		if (rd_i) begin
			if (hit(addr_i, `ACC_OFF_CTRL))
				rdata_next = {result_reg[`ACC_RES_LO_W-1:0], ctrl_reg[`ACC_BIT_EXT_EN:0]};
			else if (hit(addr_i, `ACC_OFF_CTRL2))
				rdata_next = ctrl2_reg;
			else if (hit(addr_i, `ACC_OFF_DELAY))
				rdata_next = delay_reg;
			else if (hit(addr_i, `ACC_OFF_IRQ_STAT))
				rdata_next = 8'(stat_reg);
			else if (hit(addr_i, `ACC_OFF_IRQ_MASK))
				rdata_next = 8'(mask_reg);
			else if (hit(addr_i, `ACC_OFF_RESULT_HI))
				rdata_next = result_reg[RESULT_W-1:`ACC_RES_LO_W];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign rdata_o            = rdata_reg;
	assign core_req_o.start   = start_reg;
	assign core_req_o.abort   = abort_reg;
	assign core_req_o.channel = ctrl_reg[`ACC_BIT_CH_HI:`ACC_BIT_CH_LO];
	assign irq_o              = |(stat_reg & mask_reg);

endmodule : acc_conversion_control

// >>> acc_defines.svh
// Register map, field positions, reset values and interrupt bit constants of the conversion control.
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_ADDR_W          8
`define ACC_OFF_CTRL        8'hE1
`define ACC_OFF_CTRL2       8'hF0
`define ACC_OFF_DELAY       8'hF1
`define ACC_OFF_IRQ_STAT    8'hF2
`define ACC_OFF_IRQ_MASK    8'hF3
`define ACC_OFF_RESULT_HI   8'hF4
`define ACC_BIT_RES_HI      7
`define ACC_BIT_RES_LO      6
`define ACC_BIT_EXT_EN      5
`define ACC_BIT_DONE        4
`define ACC_BIT_BUSY        3
`define ACC_BIT_CH_HI       2
`define ACC_BIT_CH_LO       0
`define ACC_BIT_TRIG_PWM    1
`define ACC_BIT_EDGE_FALL   2
`define ACC_BIT_PWM_SEL_LO  4
`define ACC_BIT_PWM_SEL_HI  5
`define ACC_CTRL_RESET      8'h00
`define ACC_CTRL2_RESET     8'h00
`define ACC_DELAY_RESET     8'h00
`define ACC_IRQ_DONE        0
`define ACC_IRQ_ABORT       1
`define ACC_IRQ_W           2
`define ACC_RES_LO_W        2
`endif

// >>> acc_pkg.sv
// Types shared by the conversion control.
package acc_pkg;
	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_DELAY,
		ACC_CONVERT,
		ACC_DONE
	} acc_state_t;

	typedef struct packed {
		logic       start;
		logic       abort;
		logic [2:0] channel;
	} acc_core_req_t;
endpackage : acc_pkg

// >>> acc_conversion_control_checker.sv
// Port assertions for the conversion control.
`timescale 1ns/1ps
`include "acc_defines.svh"
module acc_conversion_control_checker #(
	parameter int PWM_CHANNELS = 4,
	parameter int RESULT_W     = 10,
	parameter int CH_W         = 3
) (
	input wire logic                    clk_i,
	input wire logic                    rst_i,
	input wire logic [`ACC_ADDR_W-1:0]  addr_i,
	input wire logic [7:0]              wdata_i,
	input wire logic                    wr_i,
	input wire logic                    rd_i,
	input wire logic [7:0]              rdata_o,
	input wire logic                    ext_start_i,
	input wire logic [PWM_CHANNELS-1:0] pwm_i,
	input wire logic                    core_ready_i,
	input wire logic [RESULT_W-1:0]     core_result_i,
	input wire acc_pkg::acc_core_req_t  core_req_o,
	input wire logic                    irq_o
);
	logic       ctrl_wr;
	logic       run_reg, run_next, done_reg, done_next;
	logic [1:0] res_reg, res_next;
	assign ctrl_wr = wr_i && addr_i == `ACC_OFF_CTRL;
	always_comb begin
		run_next = core_req_o.start ? 1'b1 : (core_ready_i || core_req_o.abort) ? 1'b0 : run_reg;
		done_next = (run_reg && core_ready_i) ? 1'b1 : (ctrl_wr && !wdata_i[4]) ? 1'b0 : done_reg;
		res_next = (run_reg && core_ready_i) ? core_result_i[1:0] : res_reg;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_reg <= 1'b0;
			done_reg <= 1'b0;
			res_reg <= 2'h0;
		end else begin
			run_reg <= run_next;
			done_reg <= done_next;
			res_reg <= res_next;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_rd_done;
		rd_i && addr_i == `ACC_OFF_CTRL && done_reg;
	endsequence
	sequence s_rd_settled;
		s_rd_done ##0 $past(done_reg);
	endsequence
	property p_rd_zero; !rd_i |=> rdata_o == 8'h00; endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("Read data not zero.");
	property p_blocked; core_req_o.start |-> !run_reg && !done_reg; endproperty
	a_blocked: assert property (p_blocked) else $error("Start while busy or done.");
	property p_sw_start; ctrl_wr && wdata_i[3] && !wdata_i[4] && !run_reg && !done_reg
		|=> core_req_o.start; endproperty
	a_sw_start: assert property (p_sw_start) else $error("Start write lost.");
	property p_pulse; core_req_o.start |=> !core_req_o.start; endproperty
	a_pulse: assert property (p_pulse) else $error("Start pulse too long.");
	property p_abort; ctrl_wr && !wdata_i[3] && run_reg && !core_ready_i |=> core_req_o.abort;
	endproperty
	a_abort: assert property (p_abort) else $error("Abort not issued.");
	property p_sticky; s_rd_done |=> rdata_o[4]; endproperty
	a_sticky: assert property (p_sticky) else $error("Done flag lost.");
	property p_result; s_rd_done |=> rdata_o[7:6] == $past(res_reg); endproperty
	a_result: assert property (p_result) else $error("Result bits wrong.");
	property p_busy_clr; s_rd_settled |=> !rdata_o[3]; endproperty
	a_busy_clr: assert property (p_busy_clr) else $error("Busy not cleared.");
	property p_channel; ctrl_wr |=> core_req_o.channel == $past(wdata_i[2:0]); endproperty
	a_channel: assert property (p_channel) else $error("Channel wrong.");
endmodule : acc_conversion_control_checker
bind acc_conversion_control acc_conversion_control_checker #(.PWM_CHANNELS(PWM_CHANNELS),
	.RESULT_W(RESULT_W), .CH_W(CH_W)) checker_inst (.clk_i(clk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.ext_start_i(ext_start_i), .pwm_i(pwm_i), .core_ready_i(core_ready_i),
	.core_result_i(core_result_i), .core_req_o(core_req_o), .irq_o(irq_o));

// >>> acc_core_model.sv
// Behavioural converter core.
`timescale 1ns/1ps
module acc_core_model #(
	parameter logic [9:0] RESULT = 10'h2C5
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  acc_pkg::acc_core_req_t req_i,
	input  wire logic              slow_i,
	output logic                   ready_o,
	output logic [9:0]             result_o
);
	logic       act_reg, act_next;
	logic [5:0] cnt_reg, cnt_next;
	always_comb begin
		act_next = (req_i.abort || ready_o) ? 1'b0 : (req_i.start || act_reg);
		cnt_next = req_i.start ? (slow_i ? 6'h28 : 6'h03) : cnt_reg - 6'h01;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			act_reg <= 1'b0;
			cnt_reg <= 6'h00;
		end else begin
			act_reg <= act_next;
			cnt_reg <= cnt_next;
		end
	end
	assign ready_o = act_reg && cnt_reg == 6'h00;
	assign result_o = ready_o ? RESULT : ~RESULT;
endmodule : acc_core_model

// >>> acc_conversion_control_bench.sv
// Self-checking bench for the conversion control.
`timescale 1ns/1ps
module acc_conversion_control_bench;
	logic                   clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
	logic                   ext_start_i = 1'b0, slow = 1'b0, core_ready_i, irq_o;
	logic [7:0]             addr_i = 8'h00, wdata_i = 8'h00, rdata_o, last;
	logic [3:0]             pwm_i = 4'h0;
	logic [9:0]             core_result_i;
	acc_pkg::acc_core_req_t core_req_o;
	logic [7:0]             regs [5] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'h10};
	int                     bad_count = 0, comparisons = 0, cycles = 0;
	always #12.5 clk_i = ~clk_i;
	acc_conversion_control acc_conversion_control_inst (.clk_i(clk_i), .rst_i(rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.ext_start_i(ext_start_i), .pwm_i(pwm_i), .core_ready_i(core_ready_i),
		.core_result_i(core_result_i), .core_req_o(core_req_o), .irq_o(irq_o));
	acc_core_model acc_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(core_req_o),
		.slow_i(slow), .ready_o(core_ready_i), .result_o(core_result_i));
	task conclude;
		if (bad_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 last = rdata_o;
	endtask : rd
	task wait_done;
		last = 8'h00;
		for (int i = 0; i < 80; i++) if (last[4] !== 1'b1) rd(8'hE1);
	endtask : wait_done
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			conclude;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'hE1);
		chk(last, 8'h00);
		foreach (regs[i]) begin
			rd(regs[i]);
			chk(last, 8'h00);
		end
		for (int i = 0; i < 8; i++) begin
			wr(8'hE1, 8'(i));
			chk({5'h00, core_req_o.channel}, 8'(i));
		end
		wr(8'hF3, 8'h03);
		wr(8'hE1, 8'h0A);
		wait_done;
		rd(8'hE1);
		chk(last, 8'h52);
		chk({7'h00, irq_o}, 8'h01);
		rd(8'hF4);
		chk(last, 8'hB1);
		wr(8'hE1, 8'h1A);
		rd(8'hE1);
		chk(last, 8'h52);
		wr(8'hF2, 8'h01);
		chk({7'h00, irq_o}, 8'h00);
		slow <= 1'b1;
		wr(8'hE1, 8'h0A);
		rd(8'hE1);
		chk(last & 8'h1F, 8'h0A);
		wr(8'hE1, 8'h02);
		rd(8'hE1);
		chk(last & 8'h1F, 8'h02);
		rd(8'hF2);
		chk(last, 8'h02);
		wr(8'hF2, 8'h02);
		slow <= 1'b0;
		wr(8'hE1, 8'h20);
		@(posedge clk_i) ext_start_i <= 1'b1;
		wait_done;
		rd(8'hE1);
		chk(last & 8'h3F, 8'h30);
		@(posedge clk_i) ext_start_i <= 1'b0;
		wr(8'hE1, 8'h20);
		wr(8'hF0, 8'h36);
		wr(8'hF1, 8'h05);
		@(posedge clk_i) pwm_i <= 4'h9;
		repeat (12) @(posedge clk_i);
		pwm_i <= 4'h8;
		repeat (20) @(posedge clk_i);
		rd(8'hE1);
		chk(last & 8'h3F, 8'h20);
		@(posedge clk_i) pwm_i <= 4'h0;
		wait_done;
		rd(8'hE1);
		chk(last & 8'h3F, 8'h30);
		conclude;
	end
endmodule : acc_conversion_control_bench
